// ===== rtl/blru_pkg.sv
// Purpose: Shared constants and opcode type for the bitwise logic and rotate unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Opcodes are one-hot so that a single stuck or doubled bit reads as illegal.
package blru_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam int RING_W = 17;
    localparam int CNT16_W = 4;
    localparam int CNT17_W = 5;
    localparam logic [CNT17_W-1:0] RING_LEN = 5'h11;

    // ==========================================================
    // Reset values
    localparam logic [WORD_W-1:0] DST_RST = 16'h0000;
    localparam logic CARRY_RST = 1'b0;

    // ==========================================================
    // Operation select
    typedef enum logic [10:0] {
        OP_WORD_AND = 11'h001,
        OP_WORD_OR = 11'h002,
        OP_WORD_XOR = 11'h004,
        OP_WORD_NOT = 11'h008,
        OP_DWORD_AND = 11'h010,
        OP_DWORD_OR = 11'h020,
        OP_DWORD_XOR = 11'h040,
        OP_DWORD_NOT = 11'h080,
        OP_ROTATE_RIGHT = 11'h100,
        OP_ROTATE_LEFT = 11'h200,
        OP_ROTATE_RIGHT_CARRY = 11'h400
    } blru_op_t;

endpackage

// ===== rtl/blru_unit.sv
// Purpose: Word and double-word bitwise logic plus 16-bit rotates with a carry flag.
// Assumes: Sequencer holds operands steady in the cycle power_flow_en is high.
// Notes:   Result appears one cycle after the enabled request; no back-pressure.
`timescale 1ns/1ps

module blru_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from sequencer
    input wire logic power_flow_en,
    input wire blru_pkg::blru_op_t op_sel,
    input wire logic [15:0] src1_lo,
    input wire logic [15:0] src1_hi,
    input wire logic [15:0] src2_lo,
    input wire logic [15:0] src2_hi,
    input wire logic [15:0] rotate_count,
    // Result
    output logic [15:0] dst_lo,
    output logic [15:0] dst_hi,
    output logic carry_flag,
    output logic result_valid
);

    // ==========================================================
    // State
    logic [blru_pkg::WORD_W-1:0] dst_lo_r;
    logic [blru_pkg::WORD_W-1:0] dst_hi_r;
    logic carry_r;
    logic valid_r;
    logic [blru_pkg::WORD_W-1:0] lo_nxt;
    logic [blru_pkg::WORD_W-1:0] hi_nxt;
    logic carry_nxt;
    logic legal_op;

    // ==========================================================
    // Operation decode
    always_comb begin
        logic [blru_pkg::DWORD_W-1:0] dbl;
        logic [2*blru_pkg::RING_W-1:0] ring2;
        logic [blru_pkg::CNT16_W-1:0] n16;
        logic [blru_pkg::CNT17_W-1:0] n17;
        dbl = {src1_lo, src1_lo};
        ring2 = {carry_r, src1_lo, carry_r, src1_lo};
        n16 = rotate_count[blru_pkg::CNT16_W-1:0];
        // Count relies on being non-negative; taken unsigned
        n17 = blru_pkg::CNT17_W'(rotate_count % 16'(blru_pkg::RING_LEN));
        lo_nxt = dst_lo_r;
        hi_nxt = dst_hi_r;
        carry_nxt = carry_r;
        legal_op = 1'b1;
        unique case (op_sel)
            blru_pkg::OP_WORD_AND: begin
                lo_nxt = src1_lo & src2_lo;
            end
            blru_pkg::OP_WORD_OR: begin
                lo_nxt = src1_lo | src2_lo;
            end
            blru_pkg::OP_WORD_XOR: begin
                lo_nxt = src1_lo ^ src2_lo;
            end
            blru_pkg::OP_WORD_NOT: begin
                lo_nxt = ~src1_lo;
            end
            blru_pkg::OP_DWORD_AND: begin
                lo_nxt = src1_lo & src2_lo;
                hi_nxt = src1_hi & src2_hi;
            end
            blru_pkg::OP_DWORD_OR: begin
                lo_nxt = src1_lo | src2_lo;
                hi_nxt = src1_hi | src2_hi;
            end
            blru_pkg::OP_DWORD_XOR: begin
                lo_nxt = src1_lo ^ src2_lo;
                hi_nxt = src1_hi ^ src2_hi;
            end
            blru_pkg::OP_DWORD_NOT: begin
                lo_nxt = ~src1_lo;
                hi_nxt = ~src1_hi;
            end
            blru_pkg::OP_ROTATE_RIGHT: begin
                lo_nxt = 16'(dbl >> n16);
                // A full-turn count moves nothing, so carry holds
                if (n16 != '0) begin
                    carry_nxt = lo_nxt[blru_pkg::WORD_W-1];
                end
            end
            blru_pkg::OP_ROTATE_LEFT: begin
                // Upper half of the shifted doubled word is the left rotate
                lo_nxt = 16'((dbl << n16) >> blru_pkg::WORD_W);
                if (n16 != '0) begin
                    carry_nxt = lo_nxt[0];
                end
            end
            blru_pkg::OP_ROTATE_RIGHT_CARRY: begin
                ring2 = ring2 >> n17;
                lo_nxt = ring2[blru_pkg::WORD_W-1:0];
                carry_nxt = ring2[blru_pkg::WORD_W];
            end
            default: begin
                // Illegal code: treated as no operation
                legal_op = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Destination registers
    always_ff @(posedge clk) begin
        if (rst) begin
            dst_lo_r <= blru_pkg::DST_RST;
            dst_hi_r <= blru_pkg::DST_RST;
        end else if (power_flow_en && legal_op) begin
            dst_lo_r <= lo_nxt;
            dst_hi_r <= hi_nxt;
        end
    end

    // ==========================================================
    // Carry flag
    always_ff @(posedge clk) begin
        if (rst) begin
            carry_r <= blru_pkg::CARRY_RST;
        end else if (power_flow_en && legal_op) begin
            carry_r <= carry_nxt;
        end
    end

    // ==========================================================
    // Completion pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= power_flow_en && legal_op;
        end
    end

    assign dst_lo = dst_lo_r;
    assign dst_hi = dst_hi_r;
    assign carry_flag = carry_r;
    assign result_valid = valid_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic is_logic_op;
    assign is_logic_op = !(op_sel inside {blru_pkg::OP_ROTATE_RIGHT,
        blru_pkg::OP_ROTATE_LEFT, blru_pkg::OP_ROTATE_RIGHT_CARRY});

    chk_idle_hold: assert property (
        !power_flow_en |=> $stable({dst_hi, dst_lo, carry_flag}) && !result_valid)
        else $error("destination changed without power flow");
    chk_word_and: assert property (
        power_flow_en && op_sel == blru_pkg::OP_WORD_AND
        |=> dst_lo == ($past(src1_lo) & $past(src2_lo)) && $stable(dst_hi))
        else $error("word and result wrong");
    chk_word_or: assert property (
        power_flow_en && op_sel == blru_pkg::OP_WORD_OR
        |=> dst_lo == ($past(src1_lo) | $past(src2_lo)))
        else $error("word or result wrong");
    chk_word_xor: assert property (
        power_flow_en && op_sel == blru_pkg::OP_WORD_XOR
        |=> dst_lo == ($past(src1_lo) ^ $past(src2_lo)))
        else $error("word xor result wrong");
    chk_word_not: assert property (
        power_flow_en && op_sel == blru_pkg::OP_WORD_NOT |=> dst_lo == ~$past(src1_lo))
        else $error("word not result wrong");
    chk_dword_pair: assert property (
        power_flow_en && op_sel == blru_pkg::OP_DWORD_XOR
        |=> {dst_hi, dst_lo} == ({$past(src1_hi), $past(src1_lo)}
            ^ {$past(src2_hi), $past(src2_lo)}))
        else $error("double word xor result wrong");
    chk_dword_not: assert property (
        power_flow_en && op_sel == blru_pkg::OP_DWORD_NOT
        |=> {dst_hi, dst_lo} == ~{$past(src1_hi), $past(src1_lo)})
        else $error("double word not result wrong");
    chk_ror_carry: assert property (
        power_flow_en && op_sel == blru_pkg::OP_ROTATE_RIGHT && rotate_count == 16'h0001
        |=> dst_lo == {$past(src1_lo[0]), $past(src1_lo[15:1])}
            && carry_flag == $past(src1_lo[0]))
        else $error("rotate right by one wrong");
    chk_rol_carry: assert property (
        power_flow_en && op_sel == blru_pkg::OP_ROTATE_LEFT && rotate_count[3:0] != 4'h0
        |=> carry_flag == dst_lo[0] && result_valid)
        else $error("rotate left carry is not last bit out");
    chk_rcr_ring: assert property (
        power_flow_en && op_sel == blru_pkg::OP_ROTATE_RIGHT_CARRY
            && rotate_count == 16'h0001
        |=> dst_lo == {$past(carry_flag), $past(src1_lo[15:1])}
            && carry_flag == $past(src1_lo[0]))
        else $error("rotate through carry by one wrong");
    chk_logic_carry: assert property (
        power_flow_en && is_logic_op |=> $stable(carry_flag))
        else $error("logic operation touched carry");

    cov_dword_and: cover property (
        power_flow_en && op_sel == blru_pkg::OP_DWORD_AND ##1 result_valid);
    cov_ror_wrap: cover property (
        power_flow_en && op_sel == blru_pkg::OP_ROTATE_RIGHT && rotate_count > 16'h000f);
    cov_rcr_set: cover property (
        power_flow_en && op_sel == blru_pkg::OP_ROTATE_RIGHT_CARRY ##1 carry_flag);
    cov_back_to_back: cover property (power_flow_en [*3]);

endmodule

// ===== verif/blru_seq_model.sv
// Purpose: Sequencer model that issues requests to the unit.
// Assumes: Requests change on the falling edge, one enabled cycle each.
// Notes:   Idle operands invert after issue and go all ones after issue3, so stale data never looks valid.
`timescale 1ns/1ps

module blru_seq_model (
    // Clock
    input wire logic clk,
    // Request
    output logic power_flow_en,
    output blru_pkg::blru_op_t op_sel,
    output logic [15:0] src1_lo,
    output logic [15:0] src1_hi,
    output logic [15:0] src2_lo,
    output logic [15:0] src2_hi,
    output logic [15:0] rotate_count
);
    // ==========================================================
    // Requests
    initial begin
        power_flow_en = 1'b0;
        op_sel = blru_pkg::OP_WORD_AND;
        {src1_hi, src1_lo, src2_hi, src2_lo} = 64'h0;
        rotate_count = 16'h0000;
    end

    task automatic issue(input blru_pkg::blru_op_t op, input logic [31:0] a,
        input logic [31:0] b, input logic [15:0] cnt);
        @(negedge clk);
        power_flow_en = 1'b1;
        op_sel = op;
        {src1_hi, src1_lo} = a;
        {src2_hi, src2_lo} = b;
        rotate_count = cnt; // Unsigned, full word source
        @(negedge clk);
        power_flow_en = 1'b0;
        {src1_hi, src1_lo, src2_hi, src2_lo} = ~{a, b};
        rotate_count = ~cnt;
    endtask

    // Three enabled cycles back to back, so each rotate sees the carry of the one before
    task automatic issue3(input blru_pkg::blru_op_t op[3], input logic [15:0] a[3],
        input logic [15:0] cnt[3]);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            power_flow_en = 1'b1;
            op_sel = op[i];
            src1_lo = a[i];
            {src1_hi, src2_hi, src2_lo} = 48'h0;
            rotate_count = cnt[i]; // Unsigned, full word source
        end
        @(negedge clk);
        power_flow_en = 1'b0;
        {src1_hi, src1_lo, src2_hi, src2_lo} = 64'hffff_ffff_ffff_ffff;
        rotate_count = 16'hffff;
    endtask
endmodule

// ===== verif/blru_unit_tb_top.sv
// Purpose: Self-checking bench for the logic and rotate unit.
// Assumes: 250 MHz clock, synchronous reset held 8 cycles.
// Notes:   Results sampled on the falling edge after the taking edge.
`timescale 1ns/1ps

module blru_unit_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_flow_en, carry_flag, result_valid;
    blru_pkg::blru_op_t op_sel;
    logic [15:0] src1_lo, src1_hi, src2_lo, src2_hi, rotate_count, dst_lo, dst_hi;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    blru_seq_model u_seq (.clk(clk), .power_flow_en(power_flow_en), .op_sel(op_sel),
        .src1_lo(src1_lo), .src1_hi(src1_hi), .src2_lo(src2_lo), .src2_hi(src2_hi),
        .rotate_count(rotate_count));
    blru_unit u_dut (.clk(clk), .rst(rst), .power_flow_en(power_flow_en), .op_sel(op_sel),
        .src1_lo(src1_lo), .src1_hi(src1_hi), .src2_lo(src2_lo), .src2_hi(src2_hi),
        .rotate_count(rotate_count), .dst_lo(dst_lo), .dst_hi(dst_hi),
        .carry_flag(carry_flag), .result_valid(result_valid));

    // ==========================================================
    // Compare and report
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s: %b not %b", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Run takes about 46 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        cmp_word(dst_lo, 16'h0000, "rst lo");
        cmp_word(dst_hi, 16'h0000, "rst hi");
        cmp_flag(carry_flag, 1'b0, "rst carry");
        cmp_flag(result_valid, 1'b0, "rst valid");
        $display("reset done");
    endtask

    task automatic t_word();
        blru_pkg::blru_op_t ops[4] = '{blru_pkg::OP_WORD_AND, blru_pkg::OP_WORD_OR,
            blru_pkg::OP_WORD_XOR, blru_pkg::OP_WORD_NOT};
        logic [15:0] exp[4] = '{16'h9202, 16'hb7bf, 16'h25bd, 16'h496c};
        for (int i = 0; i < 4; i++) begin
            u_seq.issue(ops[i], 32'h0000b693, 32'h0000932e, 16'h0000);
            cmp_flag(result_valid, 1'b1, "valid");
            cmp_word(dst_lo, exp[i], "word");
        end
        $display("word done");
    endtask

    task automatic t_dword();
        blru_pkg::blru_op_t ops[4] = '{blru_pkg::OP_DWORD_AND, blru_pkg::OP_DWORD_OR,
            blru_pkg::OP_DWORD_XOR, blru_pkg::OP_DWORD_NOT};
        logic [31:0] exp[4] = '{32'h32222012, 32'hbabff773, 32'h889dd761, 32'h4d5919ad};
        for (int i = 0; i < 4; i++) begin
            u_seq.issue(ops[i], 32'hb2a6e652, 32'h3a3b3133, 16'h0000);
            cmp_word(dst_lo, exp[i][15:0], "dw lo");
            cmp_word(dst_hi, exp[i][31:16], "dw hi");
        end
        $display("dword done");
    endtask

    task automatic t_rot();
        blru_pkg::blru_op_t ops[5] = '{blru_pkg::OP_ROTATE_RIGHT, blru_pkg::OP_ROTATE_LEFT,
            blru_pkg::OP_ROTATE_RIGHT_CARRY, blru_pkg::OP_ROTATE_RIGHT,
            blru_pkg::OP_ROTATE_LEFT};
        logic [15:0] cnt[5] = '{16'h0003, 16'h000f, 16'h0005, 16'h0013, 16'h0010};
        logic [15:0] exp[5] = '{16'hb9b2, 16'he6ca, 16'h566c, 16'hb9b2, 16'hcd95};
        logic c[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 5; i++) begin
            u_seq.issue(ops[i], 32'h0000cd95, 32'h00000000, cnt[i]);
            cmp_word(dst_lo, exp[i], "rot");
            cmp_flag(carry_flag, c[i], "rot carry");
        end
        $display("rotate done");
    endtask

    task automatic t_keep();
        u_seq.issue(blru_pkg::OP_WORD_XOR, 32'h0000ffff, 32'h000000ff, 16'h0000);
        cmp_word(dst_lo, 16'hff00, "xor");
        cmp_flag(carry_flag, 1'b1, "carry kept");
        $display("carry keep done");
    endtask

    task automatic t_hold();
        repeat (3) @(negedge clk);
        cmp_flag(result_valid, 1'b0, "idle valid");
        cmp_word(dst_lo, 16'hff00, "idle dst");
        u_seq.issue(blru_pkg::blru_op_t'(11'h003), 32'h00001234, 32'h00005678, 16'h0001);
        cmp_flag(result_valid, 1'b0, "bad op valid");
        cmp_word(dst_lo, 16'hff00, "bad op dst");
        cmp_flag(carry_flag, 1'b1, "bad op carry");
        $display("hold done");
    endtask

    task automatic t_chain();
        blru_pkg::blru_op_t ops[3] = '{blru_pkg::OP_ROTATE_LEFT,
            blru_pkg::OP_ROTATE_RIGHT_CARRY, blru_pkg::OP_ROTATE_RIGHT_CARRY};
        logic [15:0] src[3] = '{16'hcd95, 16'h0003, 16'h0000};
        logic [15:0] cnt[3] = '{16'h000f, 16'h0001, 16'h0001};
        u_seq.issue3(ops, src, cnt);
        cmp_flag(result_valid, 1'b1, "chain valid");
        cmp_word(dst_lo, 16'h8000, "chain dst");
        cmp_flag(carry_flag, 1'b0, "chain carry");
        $display("chain done");
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_word();
        t_dword();
        t_rot();
        t_keep();
        t_hold();
        t_chain();
        report_and_stop();
    end
endmodule
